// *** verilog/dac_host_end.sv ***
// serial controller for the quad converter, commanded over axi4-lite
module dac_host_end (
	input  wire logic                         mclk,
	input  wire logic                         rst_n,
	dac_link_if.host                          link,
	input  wire logic                         awvalid,
	output logic                              awready,
	input  wire logic [dac_link_pkg::ADDR_W-1:0] awaddr,
	input  wire logic                         wvalid,
	output logic                              wready,
	input  wire logic [31:0]                  wdata,
	input  wire logic [3:0]                   wstrb,
	output logic                              bvalid,
	input  wire logic                         bready,
	output logic [1:0]                        bresp,
	input  wire logic                         arvalid,
	output logic                              arready,
	input  wire logic [dac_link_pkg::ADDR_W-1:0] araddr,
	output logic                              rvalid,
	input  wire logic                         rready,
	output logic [31:0]                       rdata,
	output logic [1:0]                        rresp
);
	import dac_link_pkg::*;

	typedef enum logic [2:0] {H_IDLE, H_SETUP, H_HIGH, H_LOW, H_END, H_GAP} host_fsm_t;

	typedef struct packed {
		logic              sout_s1;
		logic              sout_s2;
		host_fsm_t         fsm;
		logic [3:0]        cnt;
		logic [4:0]        bits;
		logic [15:0]       tx;
		cmd_word_t         rx;
		logic              sclk;
		logic              sdata;
		logic              sel_n;
		logic [CTRL_W-1:0] ctrl;
		cmd_word_t         cmd;
		logic              aw_got;
		logic [ADDR_W-1:0] waddr;
		logic              w_got;
		logic [31:0]       wbuf;
		logic [3:0]        wmask;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
	} host_state_t;

	host_state_t st;
	host_state_t next_st;
	logic        start;
	logic        tick;
	logic [31:0] merged;

	function automatic logic [31:0] strb_merge(logic [31:0] old, logic [31:0] nw,
			logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i])
				r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r;
	endfunction

	assign awready                = ~st.aw_got;
	assign wready                 = ~st.w_got;
	assign bvalid                 = st.bvalid;
	assign bresp                  = st.bresp;
	assign arready                = ~st.rvalid;
	assign rvalid                 = st.rvalid;
	assign rdata                  = st.rdata;
	assign rresp                  = st.rresp;
	assign link.ser_clk           = st.sclk;
	assign link.ser_in            = st.sdata;
	assign link.sel_n             = st.sel_n;
	assign link.hw_load_outputs_n = ~st.ctrl[CTRL_LOAD];
	assign link.async_wipe_n      = ~st.ctrl[CTRL_WIPE];

	always_comb begin
		next_st = st;
		start = 1'b0;
		merged = 32'h0;
		tick = (st.cnt == 4'h0);
		next_st.sout_s1 = link.ser_out;
		next_st.sout_s2 = st.sout_s1;
		if (awvalid && !st.aw_got) begin
			next_st.aw_got = 1'b1;
			next_st.waddr = awaddr;
		end
		if (wvalid && !st.w_got) begin
			next_st.w_got = 1'b1;
			next_st.wbuf = wdata;
			next_st.wmask = wstrb;
		end
		if (st.bvalid && bready)
			next_st.bvalid = 1'b0;
		if (st.aw_got && st.w_got && !st.bvalid) begin
			next_st.aw_got = 1'b0;
			next_st.w_got = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = RESP_OKAY;
			case (st.waddr)
				REG_CMD: begin
					merged = strb_merge(32'(st.cmd), st.wbuf, st.wmask);
					if (st.fsm == H_IDLE) begin
						next_st.cmd = merged[WORD_W-1:0];
						start = 1'b1;
					end else
						next_st.bresp = RESP_SLVERR;
				end
				REG_CTRL: begin
					merged = strb_merge(32'(st.ctrl), st.wbuf, st.wmask);
					next_st.ctrl = merged[CTRL_W-1:0];
				end
				REG_STATUS: ;
				default: next_st.bresp = RESP_SLVERR;
			endcase
		end
		if (st.rvalid && rready)
			next_st.rvalid = 1'b0;
		if (arvalid && !st.rvalid) begin
			next_st.rvalid = 1'b1;
			next_st.rresp = RESP_OKAY;
			case (araddr)
				REG_CMD: next_st.rdata = 32'(st.cmd);
				REG_CTRL: next_st.rdata = 32'(st.ctrl);
				REG_STATUS: begin
					next_st.rdata = 32'h0;
					next_st.rdata[STAT_RX_LSB +: WORD_W] = st.rx;
					next_st.rdata[STAT_BUSY_BIT] = (st.fsm != H_IDLE);
				end
				default: begin
					next_st.rdata = 32'h0;
					next_st.rresp = RESP_SLVERR;
				end
			endcase
		end
		if (st.fsm != H_IDLE)
			next_st.cnt = tick ? HALF_LAST : st.cnt - 4'h1;
		// clock idles low, data changes on fall, sampled on rise
		unique case (st.fsm)
			H_IDLE: begin
				if (start) begin
					next_st.tx = st.ctrl[CTRL_FRAME16] ? {4'h0, next_st.cmd}
						: {next_st.cmd, 4'h0};
					next_st.bits = st.ctrl[CTRL_FRAME16] ? 5'(FRAME_LONG) : 5'(FRAME_SHORT);
					next_st.sel_n = 1'b0;
					next_st.sdata = next_st.tx[15];
					next_st.cnt = SETUP_LAST;
					next_st.fsm = H_SETUP;
				end else if (!st.sel_n && !st.ctrl[CTRL_HOLD_SEL]) begin
					next_st.cnt = HALF_LAST;
					next_st.fsm = H_END;
				end
			end
			H_SETUP, H_LOW: begin
				if (tick) begin
					next_st.sclk = 1'b1;
					next_st.rx = {st.rx[WORD_W-2:0], st.sout_s2};
					next_st.fsm = H_HIGH;
				end
			end
			H_HIGH: begin
				if (tick) begin
					next_st.sclk = 1'b0;
					next_st.tx = {st.tx[14:0], 1'b0};
					next_st.bits = st.bits - 5'h1;
					if (st.bits == 5'h1)
						next_st.fsm = H_END;
					else begin
						next_st.sdata = st.tx[14];
						next_st.fsm = H_LOW;
					end
				end
			end
			H_END: begin
				if (tick) begin
					if (!st.ctrl[CTRL_HOLD_SEL]) begin
						next_st.sel_n = 1'b1;
						next_st.fsm = H_GAP;
					end else
						next_st.fsm = H_IDLE;
				end
			end
			H_GAP: begin
				if (tick)
					next_st.fsm = H_IDLE;
			end
		endcase
		// wipe and load levels follow ctrl at any time
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st <= '0;
			st.fsm <= H_IDLE;
			st.sel_n <= 1'b1;
			st.ctrl <= CTRL_RESET;
			st.cmd <= CMD_RESET;
		end else
			st <= next_st;
	end
endmodule

// *** verilog/dac_link_pkg.sv ***
// shared constants and types for the quad converter serial link
package dac_link_pkg;
	localparam int         MCLK_NS        = 5;
	localparam int         CODE_W         = 8;
	localparam int         NUM_CH         = 4;
	localparam int         WORD_W         = 12;
	localparam int         FRAME_SHORT    = 12;
	localparam int         FRAME_LONG     = 16;
	localparam int         SEL_HI_BIT     = 11;
	localparam int         SEL_LO_BIT     = 10;
	localparam int         CMD_HI_BIT     = 9;
	localparam int         CMD_LO_BIT     = 8;
	localparam int         DATA_MSB       = 7;
	localparam logic [1:0] CMD_FROM_SHIFT = 2'h0;
	localparam logic [1:0] CMD_LOAD_INPUT = 2'h1;
	localparam logic [1:0] CMD_TRANSFER   = 2'h2;
	localparam logic [1:0] CMD_LOAD_BOTH  = 2'h3;
	localparam logic [1:0] SEL_MODE_RISE  = 2'h3;
	localparam logic [1:0] SEL_MODE_FALL  = 2'h2;
	localparam int         REF_SCALE      = 256;
	localparam int         SCLK_HALF_NS   = 40;
	localparam int         CS_SETUP_NS    = 40;
	localparam logic [3:0] HALF_LAST      = 4'((SCLK_HALF_NS + MCLK_NS - 1) / MCLK_NS - 1);
	localparam logic [3:0] SETUP_LAST     = 4'((CS_SETUP_NS + MCLK_NS - 1) / MCLK_NS - 1);
	localparam int         ADDR_W         = 4;
	localparam logic [3:0] REG_CMD        = 4'h0;
	localparam logic [3:0] REG_CTRL       = 4'h4;
	localparam logic [3:0] REG_STATUS     = 4'h8;
	localparam int         CTRL_W         = 4;
	localparam int         CTRL_FRAME16   = 0;
	localparam int         CTRL_HOLD_SEL  = 1;
	localparam int         CTRL_LOAD      = 2;
	localparam int         CTRL_WIPE      = 3;
	localparam logic [3:0] CTRL_RESET     = 4'h0;
	localparam logic [11:0] CMD_RESET     = 12'h000;
	localparam int         STAT_BUSY_BIT  = 0;
	localparam int         STAT_RX_LSB    = 16;
	localparam logic [1:0] RESP_OKAY      = 2'h0;
	localparam logic [1:0] RESP_SLVERR    = 2'h2;
	typedef logic [NUM_CH-1:0][CODE_W-1:0] code_bank_t;
	typedef logic [NUM_CH-1:0][15:0]       level_bank_t;
	typedef logic [WORD_W-1:0]             cmd_word_t;
endpackage

// *** verilog/dac_link_if.sv ***
// link wires between the serial controller and the quad converter
interface dac_link_if;
	logic ser_clk;
	logic ser_in;
	logic sel_n;
	logic hw_load_outputs_n;
	logic async_wipe_n;
	logic ser_out;
	modport host (
		output ser_clk,
		output ser_in,
		output sel_n,
		output hw_load_outputs_n,
		output async_wipe_n,
		input  ser_out
	);
	modport dev (
		input  ser_clk,
		input  ser_in,
		input  sel_n,
		input  hw_load_outputs_n,
		input  async_wipe_n,
		output ser_out
	);
endinterface

// *** verilog/dac_dev_end.sv ***
// quad 8-bit converter digital end: serial link, registers, pass-through output
module dac_dev_end #(
	parameter int REF_MV = 4000
) (
	input  wire logic                       mclk,
	input  wire logic                       rst_n,
	dac_link_if.dev                         link,
	output dac_link_pkg::code_bank_t        input_code,
	output dac_link_pkg::code_bank_t        dac_code,
	output dac_link_pkg::level_bank_t       out_level_mv,
	output logic                            out_falling_mode,
	output logic                            selected,
	output logic                            cmd_strobe,
	output dac_link_pkg::cmd_word_t         last_cmd
);
	import dac_link_pkg::*;

	typedef struct packed {
		logic        sclk_s1;
		logic        sclk_s2;
		logic        sclk_d;
		logic        sel_s1;
		logic        sel_s2;
		logic        sel_d;
		logic        din_s1;
		logic        din_s2;
		logic        wipe_s1;
		logic        wipe_s2;
		logic        load_s1;
		logic        load_s2;
		cmd_word_t   shift;
		logic        stage;
		logic        sout;
		logic        mode_fall;
		code_bank_t  inp;
		code_bank_t  dac;
		level_bank_t lvl;
		logic        strobe;
		cmd_word_t   last;
	} dev_state_t;

	dev_state_t st;
	dev_state_t next_st;
	logic       clk_rise;
	logic       clk_fall;
	logic       sel_up;
	logic [1:0] ch;
	logic [1:0] cmd;
	logic [CODE_W-1:0] code;

	// scaled output in millivolts for one channel
	function automatic logic [15:0] to_level(logic [CODE_W-1:0] c);
		logic [31:0] p;
		p = 32'(c) * 32'(REF_MV);
		return 16'(p / 32'(REF_SCALE));
	endfunction

	assign link.ser_out     = st.sout;
	assign input_code       = st.inp;
	assign dac_code         = st.dac;
	assign out_level_mv     = st.lvl;
	assign out_falling_mode = st.mode_fall;
	assign selected         = st.sel_s2;
	assign cmd_strobe       = st.strobe;
	assign last_cmd         = st.last;

	always_comb begin
		next_st = st;
		next_st.sclk_s1 = link.ser_clk;
		next_st.sclk_s2 = st.sclk_s1;
		next_st.sclk_d = st.sclk_s2;
		// select, load and wipe are kept active high inside
		next_st.sel_s1 = ~link.sel_n;
		next_st.sel_s2 = st.sel_s1;
		next_st.sel_d = st.sel_s2;
		next_st.din_s1 = link.ser_in;
		next_st.din_s2 = st.din_s1;
		next_st.wipe_s1 = ~link.async_wipe_n;
		next_st.wipe_s2 = st.wipe_s1;
		next_st.load_s1 = ~link.hw_load_outputs_n;
		next_st.load_s2 = st.load_s1;
		next_st.strobe = 1'b0;

		clk_rise = st.sclk_s2 & ~st.sclk_d;
		clk_fall = ~st.sclk_s2 & st.sclk_d;
		sel_up = st.sel_d & ~st.sel_s2;
		ch = st.shift[SEL_HI_BIT:SEL_LO_BIT];
		cmd = st.shift[CMD_HI_BIT:CMD_LO_BIT];
		code = st.shift[DATA_MSB:0];

		if (st.sel_s2 && clk_rise) begin
			// only the last 12 bits of a longer frame survive
			next_st.shift = {st.shift[WORD_W-2:0], st.din_s2};
			next_st.stage = st.shift[WORD_W-1];
			if (!st.mode_fall)
				next_st.sout = st.shift[WORD_W-1];
		end
		if (st.sel_s2 && clk_fall && st.mode_fall)
			next_st.sout = st.stage;
		// deselected: sout keeps its value and is always driven

		if (sel_up) begin
			next_st.strobe = 1'b1;
			next_st.last = st.shift;
			unique case (cmd)
				CMD_LOAD_INPUT: begin
					next_st.inp[ch] = code;
				end
				CMD_LOAD_BOTH: begin
					next_st.inp[ch] = code;
					next_st.dac[ch] = code;
				end
				CMD_FROM_SHIFT: begin
					// selector low bit set: pass-through command, nothing changes
					if (!st.shift[SEL_LO_BIT]) begin
						for (int i = 0; i < NUM_CH; i++) begin
							next_st.inp[i] = code;
							next_st.dac[i] = code;
						end
					end
				end
				CMD_TRANSFER: begin
					next_st.dac = st.inp;
					if (ch == SEL_MODE_RISE)
						next_st.mode_fall = 1'b0;
					else if (ch == SEL_MODE_FALL)
						next_st.mode_fall = 1'b1;
				end
			endcase
		end

		if (st.load_s2)
			next_st.dac = next_st.inp;

		if (st.wipe_s2) begin
			next_st.inp = '0;
			next_st.dac = '0;
		end

		for (int i = 0; i < NUM_CH; i++)
			next_st.lvl[i] = to_level(st.dac[i]);
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			st <= '0;
		else
			st <= next_st;
	end
endmodule

// *** tb/dac_link_props.sv ***
// wire-level checks on the converter serial link
module dac_link_props (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic ser_clk,
	input wire logic ser_in,
	input wire logic sel_n,
	input wire logic hw_load_outputs_n,
	input wire logic async_wipe_n,
	input wire logic ser_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_q;
	logic        sel_q;
	logic        fall_mode;
	logic [4:0]  since_rise;
	logic [4:0]  since_fall;
	logic [11:0] rx_word;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	// follows the output phase from the words the device executes
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			clk_q <= 1'b0;
			sel_q <= 1'b1;
			fall_mode <= 1'b0;
			since_rise <= 5'h1f;
			since_fall <= 5'h1f;
			rx_word <= 12'h000;
		end else begin
			clk_q <= ser_clk;
			sel_q <= sel_n;
			since_rise <= (ser_clk && !clk_q) ? 5'h0 : since_rise + 5'(since_rise != 5'h1f);
			since_fall <= (!ser_clk && clk_q) ? 5'h0 : since_fall + 5'(since_fall != 5'h1f);
			if (!sel_n && ser_clk && !clk_q)
				rx_word <= {rx_word[10:0], ser_in};
			if (sel_n && !sel_q && rx_word[9:8] == 2'h2 && rx_word[11])
				fall_mode <= !rx_word[10];
		end
	end

	a_out_held_idle: assert property (sel_n [*6] |-> $stable(ser_out))
		else $error("serial output moved while deselected");
	a_rise_phase: assert property ($changed(ser_out) && !fall_mode |-> since_rise inside {[1:7]})
		else $error("serial output not launched by a rising clock edge");
	a_fall_phase: assert property ($changed(ser_out) && fall_mode |-> since_fall inside {[1:7]})
		else $error("serial output not launched by a falling clock edge");
	a_idle_clk_low: assert property (sel_n |-> !ser_clk)
		else $error("serial clock high while deselected");
	a_select_setup: assert property ($fell(sel_n) |-> !ser_clk [*8])
		else $error("select setup before first clock too short");
	a_clk_high_half: assert property ($rose(ser_clk) |-> ser_clk [*8] ##1 !ser_clk)
		else $error("serial clock high phase wrong");
	a_data_stable: assert property (ser_clk |-> $stable(ser_in))
		else $error("serial data changed while clock high");
	a_deselect_gap: assert property ($rose(sel_n) |-> sel_n [*8])
		else $error("deselect gap too short");

	c_fall_shift: cover property (fall_mode && $changed(ser_out));
	c_rise_shift: cover property (!fall_mode && $changed(ser_out));
	c_wipe: cover property (!async_wipe_n);
	c_load: cover property (!hw_load_outputs_n);
endmodule

// *** tb/tb_quad_dac_serial_control.sv ***
// self-checking bench for the quad converter serial link
module tb_quad_dac_serial_control;
	timeunit 1ns;
	timeprecision 100ps;
	import dac_link_pkg::*;
	localparam int REF = 4000;
	typedef struct packed {
		code_bank_t i;
		code_bank_t d;
		logic       m;
		cmd_word_t  w;
	} note_t;
	logic        mclk = 1'b0;
	logic        rst_n, awvalid, wvalid, bready, arvalid, rready, em, ld, s1, s2;
	logic        awready, wready, bvalid, arready, rvalid, out_falling_mode, cmd_strobe;
	logic        selected;
	logic [3:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [31:0] seed = 32'h5d828aae;
	logic [1:0]  bresp, rresp;
	logic [63:0] hist;
	logic [65:0] rn;
	code_bank_t  ei, ed, input_code, dac_code;
	level_bank_t out_level_mv;
	cmd_word_t   last_cmd, wa;
	note_t       nt;
	int          n_fail = 0;
	int          comparisons = 0;
	logic [1:0]  bq[$];
	logic [65:0] rq[$];
	note_t       sq[$];

	dac_link_if link();
	dac_host_end u_dac_host_end (.mclk, .rst_n, .link(link), .awvalid, .awready, .awaddr,
		.wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid,
		.arready, .araddr, .rvalid, .rready, .rdata, .rresp);
	dac_dev_end #(.REF_MV(REF)) u_dac_dev_end (.mclk, .rst_n, .link(link), .input_code,
		.dac_code, .out_level_mv, .out_falling_mode, .selected, .cmd_strobe, .last_cmd);
	dac_link_props u_props (.mclk, .rst_n, .ser_clk(link.ser_clk), .ser_in(link.ser_in),
		.sel_n(link.sel_n), .hw_load_outputs_n(link.hw_load_outputs_n),
		.async_wipe_n(link.async_wipe_n), .ser_out(link.ser_out));

	always #2.5 mclk = ~mclk;

	task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic level_bank_t lvl(code_bank_t d);
		for (int c = 0; c < NUM_CH; c++)
			lvl[c] = 16'(32'(d[c]) * REF / REF_SCALE);
	endfunction

	task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		bq.push_back(r);
		@(posedge mclk);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		bready <= 1'b1;
		forever begin
			@(posedge mclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m,
		input logic [1:0] r);
		rq.push_back({r, m, e});
		@(posedge mclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		forever begin
			@(posedge mclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
	endtask

	// notes the expected register state, then starts the frame
	task automatic issue(input cmd_word_t w, input logic f16, input logic wp);
		if (wp) begin
			ei = '0;
			ed = '0;
		end
		case (w[9:8])
			CMD_LOAD_INPUT: ei[w[11:10]] = w[7:0];
			CMD_LOAD_BOTH: begin
				ei[w[11:10]] = w[7:0];
				ed[w[11:10]] = w[7:0];
			end
			CMD_FROM_SHIFT: if (!w[10]) begin
				ei = {NUM_CH{w[7:0]}};
				ed = ei;
			end
			default: begin
				ed = ei;
				if (w[11]) em = (w[11:10] == SEL_MODE_FALL);
			end
		endcase
		if (ld) ed = ei;
		sq.push_back('{ei, ed, em, w});
		hist = f16 ? {hist[47:0], 4'h0, w} : {hist[51:0], w};
		axi_write(REG_CMD, {20'h0, w}, RESP_OKAY);
	endtask

	task automatic settle();
		for (int k = 0; k < 600 && cmd_strobe !== 1'b1; k++)
			@(posedge mclk);
		check("strobe", 64'(cmd_strobe), 64'h1);
		repeat (12) @(posedge mclk);
		axi_read(REG_STATUS, {4'h0, hist[24:13], 16'h0}, 32'h0fff_0001, RESP_OKAY);
	endtask

	task automatic send(input cmd_word_t w, input logic f16);
		issue(w, f16, 1'b0);
		settle();
	endtask

	always @(posedge mclk) begin
		s1 <= cmd_strobe;
		s2 <= s1;
		if (bvalid && bready)
			check("bresp", 64'(bresp), 64'(bq.pop_front()));
		if (rvalid && rready) begin
			rn = rq.pop_front();
			check("rdata", 64'(rdata & rn[63:32]), 64'(rn[31:0] & rn[63:32]));
			check("rresp", 64'(rresp), 64'(rn[65:64]));
		end
		if (s2) begin
			nt = sq.pop_front();
			check("input", 64'(input_code), 64'(nt.i));
			check("dac", 64'(dac_code), 64'(nt.d));
			check("mode", 64'(out_falling_mode), 64'(nt.m));
			check("word", 64'(last_cmd), 64'(nt.w));
			check("level", 64'(out_level_mv), 64'(lvl(nt.d)));
			check("selected", 64'(selected), 64'h0);
		end
	end

	task automatic finish_test();
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge mclk);
		n_fail++;
		finish_test();
	end

	initial begin
		{awvalid, wvalid, bready, arvalid, rready, em, ld} = '0;
		{awaddr, araddr, wdata, ei, ed, hist} = '0;
		rst_n = 1'b0;
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		axi_read(REG_CTRL, {28'h0, CTRL_RESET}, '1, RESP_OKAY);
		axi_read(REG_CMD, {20'h0, CMD_RESET}, '1, RESP_OKAY);
		axi_read(4'hc, 32'h0, '1, RESP_SLVERR);
		axi_write(4'hc, 32'h0, RESP_SLVERR);
		axi_write(REG_STATUS, 32'hffff_ffff, RESP_OKAY);
		for (int c = 0; c < NUM_CH; c++)
			send({2'(c), CMD_LOAD_INPUT, 8'(xs())}, 1'b0);
		send({2'h0, CMD_TRANSFER, 8'(xs())}, 1'b0);
		for (int c = 0; c < NUM_CH; c++)
			send({2'(c), CMD_LOAD_BOTH, 8'(xs())}, 1'b0);
		send({2'h0, CMD_FROM_SHIFT, 8'(xs())}, 1'b0);
		send({2'h1, CMD_FROM_SHIFT, 8'(xs())}, 1'b0);
		send({SEL_MODE_FALL, CMD_TRANSFER, 8'(xs())}, 1'b0);
		for (int k = 0; k < 8; k++)
			send(12'(xs()), 1'b0);
		axi_write(REG_CTRL, 32'h1, RESP_OKAY);
		send(12'(xs()), 1'b1);
		axi_write(REG_CTRL, 32'h0, RESP_OKAY);
		send({SEL_MODE_RISE, CMD_TRANSFER, 8'(xs())}, 1'b0);
		send(12'h000, 1'b0);
		// select held low across two words: only the second one executes
		axi_write(REG_CTRL, 32'h2, RESP_OKAY);
		wa = 12'(xs());
		hist = {hist[51:0], wa};
		axi_write(REG_CMD, {20'h0, wa}, RESP_OKAY);
		repeat (12) @(negedge link.ser_clk);
		repeat (12) @(posedge mclk);
		issue({2'h0, CMD_LOAD_BOTH, 8'(xs())}, 1'b0, 1'b0);
		repeat (12) @(negedge link.ser_clk);
		repeat (12) @(posedge mclk);
		axi_write(REG_CTRL, 32'h0, RESP_OKAY);
		settle();
		// overlapping command is refused and leaves the frame intact
		issue({2'h2, CMD_LOAD_BOTH, 8'(xs())}, 1'b0, 1'b0);
		axi_write(REG_CMD, 32'h0, RESP_SLVERR);
		settle();
		// wipe pulse in mid-frame
		issue({2'h3, CMD_LOAD_INPUT, 8'(xs())}, 1'b0, 1'b1);
		axi_write(REG_CTRL, 32'h8, RESP_OKAY);
		repeat (8) @(posedge mclk);
		check("wiped", 64'({input_code, dac_code}), 64'h0);
		check("selected", 64'(selected), 64'h1);
		axi_write(REG_CTRL, 32'h0, RESP_OKAY);
		settle();
		axi_write(REG_CTRL, 32'h4, RESP_OKAY);
		ld = 1'b1;
		send({2'h1, CMD_LOAD_INPUT, 8'(xs())}, 1'b0);
		axi_write(REG_CTRL, 32'h0, RESP_OKAY);
		ld = 1'b0;
		send({SEL_MODE_FALL, CMD_TRANSFER, 8'(xs())}, 1'b0);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		{ei, ed, hist, em} = '0;
		send({2'h1, CMD_FROM_SHIFT, 8'(xs())}, 1'b0);
		finish_test();
	end
endmodule
